// >>> rtl/csd_decoder.sv
// cyclic command decoder for the starter's network adapter
// Behaviour
// - commands accepted only from output assembly class 4, instance 100, attribute 3.
// - output assembly carries at most four bytes, two 16-bit words.
// - input assembly, instance 101, carries at most twelve bytes.
// - multi-byte values travel least significant byte first.
// - command bit 6 set means start, clear means stop.
// - trip reset only on a 0 to 1 change of bit 7.
// - bit 7 already set before gives no further reset.
// - bits 6 and 7 together give reset and start.
// - bit 13 selects secondary motor set when starting, else primary.
// - last written command held until overwritten or reinitialised.
// - held command reapplied when network control returns.
// - error led flashes on timeout, steady on duplicate address, else off.
// - status led flashes with address only, steady when communicating.
// - link led on while connected, activity led flashes during traffic.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module csd_decoder (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               frame_valid,
	input  wire csd_pkg::csd_frame_s frame,
	output logic      [95:0]        status_asm,
	input  wire logic [15:0]        starter_state,
	input  wire logic [31:0]        motor_current,
	input  wire logic [15:0]        trip_code,
	input  wire logic               local_command_override_setting,
	input  wire logic               reset_input_disable,
	input  wire logic               conn_timeout,
	input  wire logic               dup_ip,
	input  wire logic               has_ip,
	input  wire logic               comm_established,
	input  wire logic [1:0]         port_link,
	input  wire logic [1:0]         port_traffic,
	output csd_pkg::csd_starter_cmd_s starter_cmd,
	output logic                    led_error,
	output logic                    led_status,
	output logic      [1:0]         led_link,
	output logic      [1:0]         led_txrx,
	output logic                    irq
);

	// two-flop synchronisers for the asynchronous pin-level inputs
	logic [7:0] sync1_ff;
	logic [7:0] sync2_ff;
	logic [7:0] pins_in;
	assign pins_in = {local_command_override_setting, reset_input_disable,
		conn_timeout, dup_ip, has_ip, comm_established, port_link[1],
		port_link[0]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
		end else begin
			sync1_ff <= pins_in;
			sync2_ff <= sync1_ff;
		end
	end

	logic net_blocked;
	logic s_timeout;
	logic s_dup;
	logic s_ip;
	logic s_comm;
	logic [1:0] s_link;
	assign net_blocked = sync2_ff[7] | sync2_ff[6];
	assign s_timeout   = sync2_ff[5];
	assign s_dup       = sync2_ff[4];
	assign s_ip        = sync2_ff[3];
	assign s_comm      = sync2_ff[2];
	assign s_link      = sync2_ff[1:0];

	logic [1:0] traffic_s1_ff;
	logic [1:0] traffic_s2_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			traffic_s1_ff <= 2'h0;
			traffic_s2_ff <= 2'h0;
		end else begin
			traffic_s1_ff <= port_traffic;
			traffic_s2_ff <= traffic_s1_ff;
		end
	end

	function automatic logic frame_ok(input csd_pkg::csd_frame_s f);
		frame_ok = (f.inst == csd_pkg::ASM_OUT_INST) &&
			(f.attr == csd_pkg::ASM_ATTR) &&
			(f.nbytes <= csd_pkg::OUT_MAX_BYTES) &&
			(f.nbytes != 4'h0);
	endfunction

	// command capture and decode
	logic [15:0] cmd_ff;
	logic [15:0] nxt_cmd;
	logic        prev_rst_ff;
	logic        nxt_prev_rst;
	logic        reset_pulse_ff;
	logic        nxt_reset_pulse;
	logic [15:0] wcmd;
	logic        accept;
	logic        ctrl_clear;

	assign accept = frame_valid & frame_ok(frame);
	// byte 0 is the low byte of the word; bytes 2 and 3 are ignored
	assign wcmd = {frame.data[15:8], frame.data[7:0]};

	always_comb begin
		nxt_cmd         = cmd_ff;
		nxt_prev_rst    = prev_rst_ff;
		nxt_reset_pulse = 1'b0;
		if (ctrl_clear) begin
			nxt_cmd      = 16'h0000;
			nxt_prev_rst = 1'b0;
		end else if (accept) begin
			nxt_cmd      = wcmd;
			nxt_prev_rst = wcmd[csd_pkg::RESET_BIT];
			// reset fires only on the rising edge across updates
			nxt_reset_pulse = wcmd[csd_pkg::RESET_BIT] & ~prev_rst_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff         <= 16'h0000;
			prev_rst_ff    <= 1'b0;
			reset_pulse_ff <= 1'b0;
		end else begin
			cmd_ff         <= nxt_cmd;
			prev_rst_ff    <= nxt_prev_rst;
			reset_pulse_ff <= nxt_reset_pulse;
		end
	end

	// held run bit is masked, not lost, while the network is locked out
	csd_pkg::csd_starter_cmd_s nxt_starter;
	csd_pkg::csd_starter_cmd_s starter_ff;
	always_comb begin
		nxt_starter.run = cmd_ff[csd_pkg::RUN_BIT] & ~net_blocked;
		nxt_starter.trip_reset = reset_pulse_ff & ~net_blocked;
		nxt_starter.mset_secondary = cmd_ff[csd_pkg::MSET_BIT];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			starter_ff <= '0;
		else
			starter_ff <= nxt_starter;
	end
	assign starter_cmd = starter_ff;

	// status assembly, twelve bytes, low byte first
	logic [95:0] status_ff;
	logic [95:0] nxt_status;
	always_comb begin
		nxt_status = {16'h0000, trip_code, motor_current, 16'h0000,
			starter_state};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_ff <= '0;
		else
			status_ff <= nxt_status;
	end
	assign status_asm = status_ff;

	// flash timebase shared by the error, status and activity leds
	logic [24:0] flash_cnt_ff;
	logic [24:0] nxt_flash_cnt;
	logic        flash_ff;
	logic        nxt_flash;
	always_comb begin
		nxt_flash_cnt = flash_cnt_ff + 25'h0000001;
		nxt_flash     = flash_ff;
		if (flash_cnt_ff == 25'(csd_pkg::FLASH_HALF_CYC - 1)) begin
			nxt_flash_cnt = 25'h0000000;
			nxt_flash     = ~flash_ff;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_cnt_ff <= 25'h0000000;
			flash_ff     <= 1'b0;
		end else begin
			flash_cnt_ff <= nxt_flash_cnt;
			flash_ff     <= nxt_flash;
		end
	end

	function automatic logic led_drive(input csd_pkg::csd_led_e m,
		input logic fl);
		case (m)
			csd_pkg::LED_OFF:   led_drive = 1'b0;
			csd_pkg::LED_FLASH: led_drive = fl;
			csd_pkg::LED_ON:    led_drive = 1'b1;
			default:            led_drive = 1'b0;
		endcase
	endfunction

	csd_pkg::csd_led_e err_mode;
	csd_pkg::csd_led_e st_mode;
	always_comb begin
		err_mode = csd_pkg::LED_OFF;
		if (s_dup)
			err_mode = csd_pkg::LED_ON;
		else if (s_timeout)
			err_mode = csd_pkg::LED_FLASH;
		st_mode = csd_pkg::LED_OFF;
		if (s_comm)
			st_mode = csd_pkg::LED_ON;
		else if (s_ip)
			st_mode = csd_pkg::LED_FLASH;
	end

	logic [5:0] led_ff;
	logic [5:0] nxt_led;
	always_comb begin
		nxt_led[0]   = led_drive(err_mode, flash_ff);
		nxt_led[1]   = led_drive(st_mode, flash_ff);
		nxt_led[3:2] = s_link;
		nxt_led[5:4] = traffic_s2_ff & {2{flash_ff}};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			led_ff <= 6'h00;
		else
			led_ff <= nxt_led;
	end
	assign led_error  = led_ff[0];
	assign led_status = led_ff[1];
	assign led_link   = led_ff[3:2];
	assign led_txrx   = led_ff[5:4];

	// apb registers and interrupts; single-cycle access phase
	logic apb_wr;
	logic apb_rd;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign ctrl_clear = apb_wr && (paddr == csd_pkg::A_CTRL) && pwdata[0];

	logic [csd_pkg::EV_W-1:0] ev;
	logic [csd_pkg::EV_W-1:0] irq_st_ff;
	logic [csd_pkg::EV_W-1:0] nxt_irq_st;
	logic [csd_pkg::EV_W-1:0] irq_en_ff;
	logic [csd_pkg::EV_W-1:0] nxt_irq_en;
	logic [csd_pkg::EV_W-1:0] clr;
	logic [31:0] nxt_prdata;
	logic [31:0] prdata_ff;
	logic        nxt_slverr;
	logic        slverr_ff;

	always_comb begin
		ev = '0;
		ev[csd_pkg::EV_CMD]   = accept;
		ev[csd_pkg::EV_TRIP]  = nxt_reset_pulse;
		ev[csd_pkg::EV_RSVD]  = accept & |(wcmd & csd_pkg::CMD_RSVD_MASK);
		ev[csd_pkg::EV_BADAS] = frame_valid & ~frame_ok(frame);
		clr = '0;
		nxt_irq_en = irq_en_ff;
		if (apb_wr && paddr == csd_pkg::A_IRQ_CLR)
			clr = pwdata[csd_pkg::EV_W-1:0];
		if (apb_wr && paddr == csd_pkg::A_IRQ_EN)
			nxt_irq_en = pwdata[csd_pkg::EV_W-1:0];
		// a new event beats a clear in the same cycle
		nxt_irq_st = (irq_st_ff & ~clr) | ev;
		nxt_prdata = 32'h00000000;
		nxt_slverr = 1'b0;
		if (psel && !penable) begin
			case (paddr)
				csd_pkg::A_CTRL:    nxt_prdata = 32'h00000000;
				csd_pkg::A_CMD:     nxt_prdata = {16'h0000, cmd_ff};
				csd_pkg::A_STATE:   nxt_prdata = {26'h0000000, sync2_ff[7:6],
					starter_ff.mset_secondary, starter_ff.trip_reset,
					starter_ff.run, prev_rst_ff};
				csd_pkg::A_IRQ_ST:  nxt_prdata = {28'h0000000, irq_st_ff};
				csd_pkg::A_IRQ_EN:  nxt_prdata = {28'h0000000, irq_en_ff};
				csd_pkg::A_IRQ_CLR: nxt_prdata = 32'h00000000;
				default:            nxt_slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_ff <= '0;
			irq_en_ff <= '0;
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else begin
			irq_st_ff <= nxt_irq_st;
			irq_en_ff <= nxt_irq_en;
			prdata_ff <= nxt_prdata;
			slverr_ff <= nxt_slverr;
		end
	end

	assign prdata  = apb_rd ? prdata_ff : 32'h00000000;
	assign pslverr = psel & penable & slverr_ff;
	assign irq     = |(irq_st_ff & irq_en_ff);

endmodule // csd_decoder

`default_nettype wire

// >>> rtl/csd_pkg.sv
// package for the cyclic starter command decoder
package csd_pkg;

	localparam logic [7:0] ASM_CLASS      = 8'h04;
	localparam logic [7:0] ASM_OUT_INST   = 8'h64;
	localparam logic [7:0] ASM_IN_INST    = 8'h65;
	localparam logic [7:0] ASM_ATTR       = 8'h03;
	localparam logic [3:0] OUT_MAX_BYTES  = 4'h4;
	localparam logic [3:0] IN_MAX_BYTES   = 4'hC;

	localparam int RUN_BIT    = 6;
	localparam int RESET_BIT  = 7;
	localparam int MSET_BIT   = 13;
	localparam logic [15:0] CMD_RSVD_MASK = 16'hDF3F;

	localparam int CLK_HZ        = 125000000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int MIN_CYCLE_US  = 1000;

	localparam logic [11:0] A_CTRL    = 12'h000;
	localparam logic [11:0] A_CMD     = 12'h004;
	localparam logic [11:0] A_STATE   = 12'h008;
	localparam logic [11:0] A_IRQ_ST  = 12'h00C;
	localparam logic [11:0] A_IRQ_EN  = 12'h010;
	localparam logic [11:0] A_IRQ_CLR = 12'h014;

	localparam int EV_CMD   = 0;
	localparam int EV_TRIP  = 1;
	localparam int EV_RSVD  = 2;
	localparam int EV_BADAS = 3;
	localparam int EV_W     = 4;

	typedef struct packed {
		logic [7:0]  inst;
		logic [7:0]  attr;
		logic [3:0]  nbytes;
		logic [31:0] data;
	} csd_frame_s;

	typedef struct packed {
		logic run;
		logic trip_reset;
		logic mset_secondary;
	} csd_starter_cmd_s;

	typedef enum logic [1:0] {
		LED_OFF   = 2'b00,
		LED_FLASH = 2'b01,
		LED_ON    = 2'b10
	} csd_led_e;

endpackage

// >>> testbench/csd_scanner.sv
// scanner model: sends cyclic output frames to the decoder
`timescale 1ns/10ps
`default_nettype none

module csd_scanner (
	input  wire logic           pclk,
	output logic                frame_valid,
	output csd_pkg::csd_frame_s frame
);
	initial begin
		frame_valid = 1'b0;
		frame = '0;
	end

	// real cycle is 1 ms or more; a short gap is kept per frame
	task automatic send(input logic [7:0] inst, input logic [3:0] nb,
			input logic [15:0] word);
		@(posedge pclk);
		frame_valid <= 1'b1;
		// low byte first, bytes 2 and 3 zero
		frame <= '{inst, csd_pkg::ASM_ATTR, nb, {16'h0000, word}};
		@(posedge pclk);
		frame_valid <= 1'b0;
		// released lines must not keep showing the last frame
		frame <= ~frame;
		repeat (6) @(posedge pclk);
	endtask
endmodule // csd_scanner
`default_nettype wire

// >>> testbench/csd_decoder_assertions.sv
// port-level assertions for the command decoder
`timescale 1ns/10ps
`default_nettype none

module csd_decoder_assertions (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic [11:0]               paddr,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [31:0]               pwdata,
	input wire logic                      frame_valid,
	input wire csd_pkg::csd_frame_s       frame,
	input wire logic                      local_command_override_setting,
	input wire logic                      reset_input_disable,
	input wire logic [1:0]                port_link,
	input wire csd_pkg::csd_starter_cmd_s starter_cmd,
	input wire logic [1:0]                led_link
);
	logic       acc;
	logic       clr;
	logic       blk;
	logic [1:0] calm_ff;
	logic [1:0] nxt_calm;
	logic       prev7_ff;
	logic       nxt_prev7;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a clear in the same cycle wins over an arriving frame
	assign clr = psel && penable && pwrite && paddr == csd_pkg::A_CTRL &&
		pwdata[0];
	assign acc = frame_valid && !clr &&
		frame.inst == csd_pkg::ASM_OUT_INST &&
		frame.attr == csd_pkg::ASM_ATTR && frame.nbytes != 4'h0 &&
		frame.nbytes <= csd_pkg::OUT_MAX_BYTES;
	assign blk = local_command_override_setting || reset_input_disable;

	// calm counts quiet cycles so the input synchronisers have settled
	always_comb begin
		nxt_calm = blk ? 2'h0 : (calm_ff == 2'h3 ? 2'h3 : calm_ff + 2'h1);
		nxt_prev7 = acc ? frame.data[7] : prev7_ff;
		if (clr)
			nxt_prev7 = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calm_ff <= 2'h0;
			prev7_ff <= 1'b0;
		end else begin
			calm_ff <= nxt_calm;
			prev7_ff <= nxt_prev7;
		end
	end

	a_run_start: assert property (
		acc && frame.data[6] && calm_ff == 2'h3 |-> ##2 starter_cmd.run)
		else $error("run not issued after start word");
	a_run_stop: assert property (
		acc && !frame.data[6] |-> ##2 !starter_cmd.run)
		else $error("run kept after stop word");
	a_trip_edge: assert property (
		acc && frame.data[7] && !prev7_ff && calm_ff == 2'h3
		|-> ##2 starter_cmd.trip_reset)
		else $error("trip reset missing on rising reset bit");
	a_trip_repeat: assert property (
		acc && frame.data[7] && prev7_ff |-> ##2 !starter_cmd.trip_reset)
		else $error("trip reset repeated on held reset bit");
	a_trip_cause: assert property (
		starter_cmd.trip_reset |-> $past(acc, 2) && !$past(prev7_ff, 2))
		else $error("trip reset without accepted rising edge");
	a_trip_pulse: assert property (
		starter_cmd.trip_reset |=> !starter_cmd.trip_reset)
		else $error("trip reset longer than one cycle");
	a_mset_sel: assert property (
		acc |-> ##2 starter_cmd.mset_secondary == $past(frame.data[13], 2))
		else $error("motor set differs from bit 13");
	a_link_led: assert property (
		port_link[0] [*4] |-> led_link[0])
		else $error("link indicator off while connected");

	c_trip: cover property (starter_cmd.trip_reset);
	c_run: cover property ($rose(starter_cmd.run));
	c_accept: cover property (acc && frame.data[13]);
endmodule // csd_decoder_assertions

bind csd_decoder csd_decoder_assertions chk_u (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.frame_valid(frame_valid), .frame(frame),
	.local_command_override_setting(local_command_override_setting),
	.reset_input_disable(reset_input_disable), .port_link(port_link),
	.starter_cmd(starter_cmd), .led_link(led_link));
`default_nettype wire

// >>> testbench/csd_decoder_bench.sv
// self-checking bench for the cyclic command decoder
`timescale 1ns/10ps
`default_nettype none

module csd_decoder_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        frame_valid, ovr, rdis, dup, hip, comm, er, irq, tmo;
	logic        led_error, led_status;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  plink, led_link, led_txrx, traf;
	logic [95:0] status_asm;
	int          err_total, total_checks, trips;
	csd_pkg::csd_frame_s       frame;
	csd_pkg::csd_starter_cmd_s cmd;

	csd_decoder dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_valid(frame_valid), .frame(frame), .status_asm(status_asm),
		.starter_state(16'h1234), .motor_current(32'h00010D42),
		.trip_code(16'h0021), .local_command_override_setting(ovr),
		.reset_input_disable(rdis), .conn_timeout(tmo), .dup_ip(dup),
		.has_ip(hip), .comm_established(comm), .port_link(plink),
		.port_traffic(traf), .starter_cmd(cmd), .led_error(led_error),
		.led_status(led_status), .led_link(led_link), .led_txrx(led_txrx),
		.irq(irq));
	csd_scanner scn_u (.pclk(pclk), .frame_valid(frame_valid), .frame(frame));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) if (cmd.trip_reset === 1'b1) trips++;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_decode();
		scn_u.send(8'h64, 4'h2, 16'h2040);
		chk("run", cmd.run, 1'b1);
		chk("mset", cmd.mset_secondary, 1'b1);
		apb(1'b0, csd_pkg::A_CMD, 32'h0);
		chk("held", rd, 32'h00002040);
		scn_u.send(8'h64, 4'h2, 16'h0080);
		scn_u.send(8'h64, 4'h2, 16'h0080);
		chk("stop", cmd.run, 1'b0);
		chk("trips", trips, 1);
		scn_u.send(8'h64, 4'h2, 16'h0000);
		scn_u.send(8'h64, 4'h2, 16'h00C0);
		chk("both", {trips[3:0], cmd.run}, 5'h05);
		chk("mset0", cmd.mset_secondary, 1'b0);
		chk("asm_lo", status_asm[31:0], 32'h00001234);
		chk("asm_mid", status_asm[63:32], 32'h00010D42);
		chk("asm_hi", status_asm[95:64], 32'h00000021);
		$display("decode test done");
	endtask
	task automatic t_override();
		ovr <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("forced", cmd.run, 1'b0);
		ovr <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("resumed", cmd.run, 1'b1);
		rdis <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("disabled", cmd.run, 1'b0);
		rdis <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("back", cmd.run, 1'b1);
		apb(1'b1, csd_pkg::A_CTRL, 32'h1);
		repeat (4) @(posedge pclk);
		chk("cleared", cmd.run, 1'b0);
		$display("override test done");
	endtask
	task automatic t_reject();
		apb(1'b1, csd_pkg::A_IRQ_EN, 32'h8);
		scn_u.send(8'h65, 4'h2, 16'h0040);
		scn_u.send(8'h64, 4'h5, 16'h0040);
		chk("reject", {irq, cmd.run}, 2'b10);
		apb(1'b1, csd_pkg::A_IRQ_CLR, 32'h8);
		@(posedge pclk);
		chk("irqclr", irq, 1'b0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("unmapped", er, 1'b1);
		$display("reject test done");
	endtask
	task automatic t_leds();
		// the first flash half-period is dark and outlasts the whole run
		tmo <= 1'b1;
		traf <= 2'b11;
		plink <= 2'b01;
		repeat (6) @(posedge pclk);
		chk("errflash", led_error, 1'b0);
		chk("statflash", led_status, 1'b0);
		chk("txrx", led_txrx, 2'b00);
		dup <= 1'b1;
		comm <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("err", led_error, 1'b1);
		chk("stat", led_status, 1'b1);
		chk("link", led_link, 2'b01);
		$display("led test done");
	endtask

	initial begin
		{presetn, psel, penable, pwrite, ovr, rdis, dup, comm, tmo} = '0;
		{paddr, pwdata, plink, traf, err_total, total_checks, trips} = '0;
		hip = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_decode();
		t_override();
		t_reject();
		t_leds();
		end_of_test();
	end
endmodule // csd_decoder_bench
`default_nettype wire
